// File: verilog/ecss_pkg.sv
/*
 * ecss_pkg: constants, types and register map for the external bus
 * chip-select and data-move stretch block.
 * Assumes a single 125 MHz APB clock; register byte address is four
 * times the register index.
 */
package ecss_pkg;
	// ==========================================================
	// register indices (byte address = index * 4)
	localparam logic [7:0] IDX_CLK_STRETCH = 8'h8e;
	localparam logic [7:0] IDX_PORT1       = 8'h90;
	localparam logic [7:0] IDX_CON_01      = 8'h92;
	localparam logic [7:0] IDX_CON_23      = 8'h93;
	localparam logic [7:0] IDX_CS0_LO      = 8'h94;
	localparam logic [7:0] IDX_CS0_HI      = 8'h95;
	localparam logic [7:0] IDX_CS1_LO      = 8'h96;
	localparam logic [7:0] IDX_CS1_HI      = 8'h97;
	localparam logic [7:0] IDX_CS2_LO      = 8'h9a;
	localparam logic [7:0] IDX_CS2_HI      = 8'h9b;
	localparam logic [7:0] IDX_CS3_LO      = 8'h9c;
	localparam logic [7:0] IDX_CS3_HI      = 8'h9d;
	localparam logic [7:0] IDX_CS_POL      = 8'ha2;
	localparam logic [7:0] IDX_PORT4       = 8'ha5;
	localparam logic [7:0] IDX_PORT1_LATCH = 8'hb0;
	localparam logic [7:0] IDX_PORT4_LATCH = 8'hb1;
	// ==========================================================
	// reset values
	localparam logic [7:0] RST_CLK_STRETCH = 8'h01;
	localparam logic [7:0] RST_PORT        = 8'hff;
	localparam logic [7:0] RST_ZERO        = 8'h00;
	// ==========================================================
	// field layout
	localparam int STRETCH_LSB = 0;
	localparam int STRETCH_W   = 3;
	localparam int POL_LSB     = 4;
	localparam int NPIN        = 4;
	localparam int NIB         = 4;
	localparam int MODE_LSB    = 2;
	localparam int CMP_LSB     = 0;
	localparam int DIV_W       = 8;
	// ==========================================================
	// pin modes and compare widths
	localparam logic [1:0] MODE_GPIO = 2'h0;
	localparam logic [1:0] MODE_RD   = 2'h1;
	localparam logic [1:0] MODE_WR   = 2'h2;
	localparam logic [1:0] MODE_RW   = 2'h3;
	localparam logic [1:0] CMP_FULL  = 2'h0;
	localparam logic [1:0] CMP_A15_1 = 2'h1;
	localparam logic [1:0] CMP_A15_2 = 2'h2;
	localparam logic [1:0] CMP_PAGE  = 2'h3;
	// machine cycles of address phase, and of an on-chip data phase
	localparam logic [3:0] MC_ONE    = 4'h1;

	typedef enum logic [1:0] {ECSS_IDLE, ECSS_ADDR, ECSS_STRB} ecss_phase_t;

	typedef struct packed {
		logic        write;
		logic        onchip;
		logic [15:0] addr;
		logic [7:0]  wdata;
	} ecss_move_t;
endpackage

// File: verilog/ecss_top.sv
/*
 * ecss_top: chip-select generation on four spare port pins, general
 * purpose port one, and the stretched external data-move sequencer,
 * with an APB register slave.
 * Assumes the core issues one data move at a time through a valid /
 * ready pair, and that pins are pulled up outside the chip.
 */
// The implementer's own choice: register access over APB.
`timescale 1ns/1ps
module ecss_top
	import ecss_pkg::*;
#(
	parameter int CLKS_PER_MC = 4
) (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic [31:0]      prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        move_valid,
	input  wire ecss_move_t  move_req,
	output logic             move_ready,
	output logic             move_done,
	output logic [7:0]       move_rdata,
	output logic [15:0]      ext_addr,
	output logic             ext_rd_n,
	output logic             ext_wr_n,
	output logic [7:0]       ext_dout,
	output logic             ext_doe,
	input  wire logic [7:0]  ext_din,
	input  wire logic [7:0]  port1_in,
	output logic [7:0]       port1_out,
	output logic [7:0]       port1_oe,
	input  wire logic [3:0]  cs_pin_in,
	output logic [3:0]       cs_pin_out,
	output logic [3:0]       cs_pin_oe
);
	// ==========================================================
	// state
	typedef struct packed {
		ecss_phase_t          phase;
		ecss_move_t           mv;
		logic [2:0]           stretch;
		logic [DIV_W-1:0]     div;
		logic [3:0]           mc_left;
		logic                 done;
		logic [7:0]           rdata;
		logic [7:0]           clk_stretch;
		logic [7:0]           port1;
		logic [3:0]           port4;
		logic [7:0]           con_01;
		logic [7:0]           con_23;
		logic [NPIN-1:0][7:0] base_lo;
		logic [NPIN-1:0][7:0] base_hi;
		logic [3:0]           pol;
		logic [7:0]           port1_meta;
		logic [7:0]           port1_sync;
		logic [3:0]           p4_meta;
		logic [3:0]           p4_sync;
		logic [7:0]           din_meta;
		logic [7:0]           din_sync;
		logic [31:0]          prdata;
		logic                 pslverr;
	} ecss_state_t;

	ecss_state_t s;
	ecss_state_t next_s;

	localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(CLKS_PER_MC - 1);

	// ==========================================================
	// helpers
	function automatic logic addr_match(input logic [15:0] a, input logic [7:0] lo,
			input logic [7:0] hi, input logic [1:0] cmp);
		logic [15:0] base;
		base = {hi, lo};
		unique case (cmp)
			CMP_FULL:  addr_match = (a == base);
			CMP_A15_1: addr_match = (a[15:1] == base[15:1]);
			CMP_A15_2: addr_match = (a[15:2] == base[15:2]);
			CMP_PAGE:  addr_match = (a[15:8] == hi);
		endcase
	endfunction

	function automatic logic [3:0] pin_nibble(input logic [7:0] c01, input logic [7:0] c23,
			input int unsigned pin);
		logic [15:0] all;
		all = {c23, c01};
		pin_nibble = all[pin*NIB +: NIB];
	endfunction

	// ==========================================================
	// derived signals
	logic       idx_ok;
	logic [7:0] idx;
	logic       mc_tick;
	logic       strobe;
	logic [3:0] cs_active;
	logic [3:0] gpio_mask;
	logic [3:0] hit;
	logic       apb_wr;
	logic       apb_setup;

	assign idx       = paddr[9:2];
	assign apb_setup = psel & ~penable;
	assign apb_wr    = psel & penable & pwrite;
	assign mc_tick   = (s.phase != ECSS_IDLE) && (s.div == DIV_LAST);
	// on-chip moves never drive the external strobes
	assign strobe    = (s.phase == ECSS_STRB) && !s.mv.onchip;

	always_comb begin
		logic [3:0] nib;
		nib       = '0;
		hit       = '0;
		cs_active = '0;
		gpio_mask = '0;
		for (int unsigned i = 0; i < NPIN; i++) begin
			nib    = pin_nibble(s.con_01, s.con_23, i);
			// every pin decodes identically from its own base pair
			hit[i] = addr_match(s.mv.addr, s.base_lo[i], s.base_hi[i],
				nib[CMP_LSB +: 2]);
			unique case (nib[MODE_LSB +: 2])
				MODE_GPIO: gpio_mask[i] = 1'b1;
				MODE_RD:   cs_active[i] = strobe && !s.mv.write && hit[i];
				MODE_WR:   cs_active[i] = strobe && s.mv.write && hit[i];
				MODE_RW:   cs_active[i] = strobe && hit[i];
			endcase
		end
	end

	// ==========================================================
	// pins
	always_comb begin
		for (int unsigned i = 0; i < NPIN; i++) begin
			if (gpio_mask[i]) begin
				// quasi-bidirectional: only a zero is driven, pull-up gives one
				cs_pin_out[i] = 1'b0;
				cs_pin_oe[i]  = ~s.port4[i];
			end else begin
				cs_pin_out[i] = s.pol[i] ? cs_active[i] : ~cs_active[i];
				cs_pin_oe[i]  = 1'b1;
			end
		end
	end

	assign port1_out  = '0;
	assign port1_oe   = ~s.port1;
	assign ext_addr   = s.mv.addr;
	assign ext_rd_n   = ~(strobe && !s.mv.write);
	assign ext_wr_n   = ~(strobe && s.mv.write);
	assign ext_dout   = s.mv.wdata;
	assign ext_doe    = (s.phase != ECSS_IDLE) && s.mv.write && !s.mv.onchip;
	assign move_ready = (s.phase == ECSS_IDLE);
	assign move_done  = s.done;
	assign move_rdata = s.rdata;
	assign prdata     = s.prdata;
	assign pslverr    = s.pslverr;
	assign pready     = 1'b1;

	// ==========================================================
	// register read decode
	always_comb begin
		idx_ok = 1'b1;
		unique case (idx)
			IDX_CLK_STRETCH, IDX_PORT1, IDX_CON_01, IDX_CON_23,
			IDX_CS0_LO, IDX_CS0_HI, IDX_CS1_LO, IDX_CS1_HI,
			IDX_CS2_LO, IDX_CS2_HI, IDX_CS3_LO, IDX_CS3_HI,
			IDX_CS_POL, IDX_PORT4, IDX_PORT1_LATCH, IDX_PORT4_LATCH: idx_ok = 1'b1;
			default: idx_ok = 1'b0;
		endcase
		if (paddr[1:0] != 2'h0 || paddr[11:10] != 2'h0) begin
			idx_ok = 1'b0;
		end
	end

	// ==========================================================
	// next state
	always_comb begin
		logic [7:0] rd;
		rd     = '0;
		next_s = s;
		next_s.done = 1'b0;
		// synchronisers: stage one is read by stage two only
		next_s.port1_meta = port1_in;
		next_s.port1_sync = s.port1_meta;
		next_s.p4_meta  = cs_pin_in;
		next_s.p4_sync  = s.p4_meta;
		next_s.din_meta = ext_din;
		next_s.din_sync = s.din_meta;

		// read data is prepared in the setup cycle so it comes from flops
		if (apb_setup) begin
			unique case (idx)
				IDX_CLK_STRETCH: rd = s.clk_stretch;
				IDX_PORT1:       rd = s.port1_sync;
				IDX_CON_01:      rd = s.con_01;
				IDX_CON_23:      rd = s.con_23;
				IDX_CS0_LO:      rd = s.base_lo[0];
				IDX_CS0_HI:      rd = s.base_hi[0];
				IDX_CS1_LO:      rd = s.base_lo[1];
				IDX_CS1_HI:      rd = s.base_hi[1];
				IDX_CS2_LO:      rd = s.base_lo[2];
				IDX_CS2_HI:      rd = s.base_hi[2];
				IDX_CS3_LO:      rd = s.base_lo[3];
				IDX_CS3_HI:      rd = s.base_hi[3];
				IDX_CS_POL:      rd = {s.pol, 4'h0};
				IDX_PORT4:       rd = {4'h0, s.p4_sync};
				IDX_PORT1_LATCH: rd = s.port1;
				IDX_PORT4_LATCH: rd = {4'h0, s.port4};
				default:         rd = '0;
			endcase
			next_s.prdata  = {24'h0, rd};
			next_s.pslverr = ~idx_ok;
		end

		if (apb_wr && idx_ok) begin
			unique case (idx)
				IDX_CLK_STRETCH: next_s.clk_stretch = pwdata[7:0];
				IDX_PORT1, IDX_PORT1_LATCH: next_s.port1 = pwdata[7:0];
				IDX_CON_01:      next_s.con_01 = pwdata[7:0];
				IDX_CON_23:      next_s.con_23 = pwdata[7:0];
				IDX_CS0_LO:      next_s.base_lo[0] = pwdata[7:0];
				IDX_CS0_HI:      next_s.base_hi[0] = pwdata[7:0];
				IDX_CS1_LO:      next_s.base_lo[1] = pwdata[7:0];
				IDX_CS1_HI:      next_s.base_hi[1] = pwdata[7:0];
				IDX_CS2_LO:      next_s.base_lo[2] = pwdata[7:0];
				IDX_CS2_HI:      next_s.base_hi[2] = pwdata[7:0];
				IDX_CS3_LO:      next_s.base_lo[3] = pwdata[7:0];
				IDX_CS3_HI:      next_s.base_hi[3] = pwdata[7:0];
				IDX_CS_POL:      next_s.pol = pwdata[POL_LSB +: NPIN];
				IDX_PORT4, IDX_PORT4_LATCH: next_s.port4 = pwdata[3:0];
				default: next_s.pslverr = s.pslverr;
			endcase
		end

		// move sequencer; the stretch is sampled at start so a mid-move
		// write cannot change the length of a move in flight
		unique case (s.phase)
			ECSS_IDLE: begin
				next_s.div = '0;
				if (move_valid) begin
					next_s.mv      = move_req;
					next_s.stretch = s.clk_stretch[STRETCH_LSB +: STRETCH_W];
					next_s.phase   = ECSS_ADDR;
					next_s.mc_left = MC_ONE;
				end
			end
			ECSS_ADDR, ECSS_STRB: begin
				next_s.div = mc_tick ? '0 : DIV_W'(s.div + 1'b1);
				if (mc_tick) begin
					next_s.mc_left = 4'(s.mc_left - 1'b1);
					if (s.mc_left == MC_ONE) begin
						if (s.phase == ECSS_ADDR) begin
							next_s.phase   = ECSS_STRB;
							// total = address cycle + stretch + 1 (or 1 on chip)
							next_s.mc_left = s.mv.onchip ? MC_ONE
								: 4'({1'b0, s.stretch} + MC_ONE);
						end else begin
							next_s.phase = ECSS_IDLE;
							next_s.done  = 1'b1;
							next_s.rdata = s.din_sync;
						end
					end
				end
			end
			default: next_s.phase = ECSS_IDLE;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s             <= '0;
			s.phase       <= ECSS_IDLE;
			s.clk_stretch <= RST_CLK_STRETCH;
			s.port1       <= RST_PORT;
			s.port4       <= RST_PORT[3:0];
			s.con_01      <= RST_ZERO;
			s.con_23      <= RST_ZERO;
		end else begin
			s <= next_s;
		end
	end

	// ==========================================================
	// checks
	logic [7:0] mc_count;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mc_count <= '0;
		end else if (move_valid && move_ready) begin
			mc_count <= '0;
		end else if (mc_tick) begin
			mc_count <= 8'(mc_count + 1'b1);
		end
	end

	a_move_len_ext: assert property (@(posedge pclk) disable iff (!presetn)
		move_done && !s.mv.onchip |-> mc_count == 8'({5'h0, s.stretch} + 8'h2))
		else $error("external move length wrong");
	a_move_len_chip: assert property (@(posedge pclk) disable iff (!presetn)
		move_done && s.mv.onchip |-> mc_count == 8'h2)
		else $error("on-chip move not two machine cycles");
	a_strobe_quiet: assert property (@(posedge pclk) disable iff (!presetn)
		s.mv.onchip || s.phase != ECSS_STRB |-> ext_rd_n && ext_wr_n)
		else $error("strobe outside external data phase");
	a_stretch_reset: assert property (@(posedge pclk)
		$rose(presetn) |-> s.clk_stretch[STRETCH_LSB +: STRETCH_W] == 3'h1)
		else $error("stretch not one after reset");
	a_cs_needs_strobe: assert property (@(posedge pclk) disable iff (!presetn)
		(cs_pin_oe & ~gpio_mask & ~(cs_pin_out ^ s.pol)) != 4'h0 |-> !ext_rd_n || !ext_wr_n)
		else $error("chip select active without strobe");
	a_cs_rd_mode: assert property (@(posedge pclk) disable iff (!presetn)
		s.con_01[MODE_LSB +: 2] == MODE_RD && !ext_wr_n |-> cs_pin_out[0] == ~s.pol[0])
		else $error("read-only select fired on write");
	a_cs_wr_page: assert property (@(posedge pclk) disable iff (!presetn)
		s.con_01[NIB +: NIB] == {MODE_WR, CMP_PAGE} && !ext_wr_n
		&& ext_addr[15:8] == s.base_hi[1] |-> cs_pin_out[1] == s.pol[1])
		else $error("page select missed");
	a_gpio_drive: assert property (@(posedge pclk) disable iff (!presetn)
		((cs_pin_oe ^ ~s.port4) & gpio_mask) == 4'h0)
		else $error("gpio pin drive wrong");
	a_port_read: assert property (@(posedge pclk) disable iff (!presetn)
		apb_setup && idx == IDX_PORT1 && paddr[1:0] == 2'h0 && paddr[11:10] == 2'h0
		|=> prdata[7:0] == $past(s.port1_sync))
		else $error("port read did not return pins");
endmodule

// File: dv/ecss_ext_mem.sv
/*
 * ecss_ext_mem: byte-wide external memory on the low address byte.
 * Assumes active-low strobes; lat sets the access time in clocks.
 */
`timescale 1ns/1ps
module ecss_ext_mem (
	input  wire logic        pclk,
	input  wire logic [15:0] ext_addr,
	input  wire logic        ext_rd_n,
	input  wire logic        ext_wr_n,
	input  wire logic [7:0]  ext_dout,
	input  wire logic        ext_doe,
	input  wire logic [3:0]  lat,
	output logic [7:0]       ext_din
);
	logic [7:0] mem [256];
	logic [7:0] last;
	logic [3:0] cnt;
	logic       vld;
	// ==========
	// storage
	initial begin
		for (int i = 0; i < 256; i++) begin
			mem[i] = 8'(i) ^ 8'h5a;
		end
		last = 8'h00;
		cnt = 4'h0;
	end
	// a slow part shows no data until lat clocks into the strobe
	assign vld = !ext_rd_n && cnt >= lat;
	// a released bus shows the inverse of the last byte, never a stale copy
	assign ext_din = vld ? mem[ext_addr[7:0]] : ~last;
	always @(posedge pclk) begin
		cnt <= ext_rd_n ? 4'h0 : (cnt == 4'hf ? cnt : cnt + 4'h1);
		if (vld) begin
			last <= ext_din;
		end
		if (!ext_wr_n && ext_doe) begin
			mem[ext_addr[7:0]] <= ext_dout;
		end
	end
endmodule

// File: dv/tb_external_bus_chip_select_stretch.sv
/*
 * tb_external_bus_chip_select_stretch: self-checking bench for ecss_top.
 * Assumes ecss_ext_mem on the strobes and pulled-up port pins.
 */
`timescale 1ns/1ps
module tb_external_bus_chip_select_stretch import ecss_pkg::*;;
	localparam int CPM = 4;
	typedef struct packed {
		logic [1:0]  pin;
		logic [1:0]  mode;
		logic [1:0]  cmp;
		logic        pol;
		logic [2:0]  st;
		logic        onchip;
		logic        wr;
		logic [15:0] base;
		logic [15:0] addr;
		logic        hit;
	} ecss_row_t;
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, e;
	logic        move_valid, move_ready, move_done, ext_rd_n, ext_wr_n, ext_doe;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	ecss_move_t  move_req;
	logic [7:0]  move_rdata, ext_dout, ext_din, port1_in, port1_out, port1_oe, pin1_drv;
	logic [15:0] ext_addr;
	logic [3:0]  cs_pin_in, cs_pin_out, cs_pin_oe, lat;
	int          num_errors, n_tests, cyc, stb, cs, both, n;
	ecss_row_t   r;
	logic [7:0]  lo_idx [4] = '{IDX_CS0_LO, IDX_CS1_LO, IDX_CS2_LO, IDX_CS3_LO};
	logic [7:0]  hi_idx [4] = '{IDX_CS0_HI, IDX_CS1_HI, IDX_CS2_HI, IDX_CS3_HI};
	logic [7:0]  rs_idx [5] = '{IDX_CLK_STRETCH, IDX_CON_01, IDX_CON_23, IDX_CS0_HI, IDX_CS_POL};
	logic [7:0]  rs_val [5] = '{8'h01, 8'h00, 8'h00, 8'h00, 8'h00};
	ecss_row_t   rows [13] = '{
		'{2'h0, MODE_RD, CMP_FULL, 1'h0, 3'h1, 1'h0, 1'h0, 16'h1234, 16'h1234, 1'h1},
		'{2'h0, MODE_RD, CMP_FULL, 1'h0, 3'h1, 1'h0, 1'h0, 16'h1234, 16'h1235, 1'h0},
		'{2'h0, MODE_RD, CMP_FULL, 1'h0, 3'h1, 1'h0, 1'h1, 16'h1234, 16'h1234, 1'h0},
		'{2'h1, MODE_WR, CMP_A15_1, 1'h1, 3'h0, 1'h0, 1'h1, 16'h4566, 16'h4567, 1'h1},
		'{2'h1, MODE_WR, CMP_A15_1, 1'h1, 3'h0, 1'h0, 1'h1, 16'h4566, 16'h4565, 1'h0},
		'{2'h2, MODE_RW, CMP_A15_2, 1'h0, 3'h2, 1'h0, 1'h0, 16'h8000, 16'h8003, 1'h1},
		'{2'h2, MODE_RW, CMP_A15_2, 1'h0, 3'h2, 1'h0, 1'h1, 16'h8000, 16'h8003, 1'h1},
		'{2'h2, MODE_RW, CMP_A15_2, 1'h0, 3'h2, 1'h0, 1'h0, 16'h8000, 16'h8004, 1'h0},
		'{2'h3, MODE_RW, CMP_PAGE, 1'h1, 3'h7, 1'h0, 1'h1, 16'hab12, 16'habff, 1'h1},
		'{2'h3, MODE_RW, CMP_PAGE, 1'h1, 3'h7, 1'h0, 1'h1, 16'hab12, 16'hac00, 1'h0},
		'{2'h0, MODE_RD, CMP_FULL, 1'h1, 3'h7, 1'h1, 1'h0, 16'h1234, 16'h1234, 1'h0},
		'{2'h1, MODE_WR, CMP_PAGE, 1'h0, 3'h1, 1'h0, 1'h1, 16'h5a00, 16'h5a77, 1'h1},
		'{2'h0, MODE_GPIO, CMP_FULL, 1'h0, 3'h0, 1'h0, 1'h0, 16'h1238, 16'h1238, 1'h0}};

	ecss_top #(.CLKS_PER_MC(CPM)) u_dut (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.move_valid(move_valid), .move_req(move_req), .move_ready(move_ready),
		.move_done(move_done), .move_rdata(move_rdata), .ext_addr(ext_addr),
		.ext_rd_n(ext_rd_n), .ext_wr_n(ext_wr_n), .ext_dout(ext_dout), .ext_doe(ext_doe),
		.ext_din(ext_din), .port1_in(port1_in), .port1_out(port1_out), .port1_oe(port1_oe),
		.cs_pin_in(cs_pin_in), .cs_pin_out(cs_pin_out), .cs_pin_oe(cs_pin_oe));
	ecss_ext_mem u_mem (.pclk(pclk), .ext_addr(ext_addr), .ext_rd_n(ext_rd_n),
		.ext_wr_n(ext_wr_n), .ext_dout(ext_dout), .ext_doe(ext_doe), .lat(lat),
		.ext_din(ext_din));
	// port-four pins float high through pull-ups when nobody drives them; undriven port-one pins show pin1_drv
	assign port1_in = (port1_oe & port1_out) | (~port1_oe & pin1_drv);
	assign cs_pin_in = (cs_pin_oe & cs_pin_out) | ~cs_pin_oe;

	initial begin
		pclk = 1'b0;
		forever #4 pclk = ~pclk;
	end
	// ==========
	// tasks
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			num_errors++;
			$display("BAD %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic apb(input logic w, input logic [7:0] idx, input logic [7:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= {2'h0, idx, 2'h0};
		pwdata <= {24'h0, d};
		@(posedge pclk);
		penable <= 1'b1;
		// the wait ends on the first clock that sees pready high
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		rd = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic wreg(input logic [7:0] idx, input logic [7:0] d);
		apb(1'b1, idx, d);
	endtask
	task automatic rreg(input logic [7:0] idx, input logic [7:0] exp, input logic err);
		apb(1'b0, idx, 8'h00);
		chk(rd, {24'h0, exp});
		chk({31'h0, e}, {31'h0, err});
	endtask
	task automatic cfg(input ecss_row_t c);
		logic [7:0] nib;
		nib = 8'({c.mode, c.cmp}) << (4 * c.pin[0]);
		wreg(c.pin[1] ? IDX_CON_23 : IDX_CON_01, nib);
		rreg(c.pin[1] ? IDX_CON_23 : IDX_CON_01, nib, 1'b0);
		wreg(lo_idx[c.pin], c.base[7:0]);
		wreg(hi_idx[c.pin], c.base[15:8]);
		wreg(IDX_CS_POL, 8'(c.pol) << (4 + c.pin));
		wreg(IDX_CLK_STRETCH, {5'h0, c.st});
	endtask
	// counts clocks to done, strobe cycles and select cycles seen on one pin
	task automatic mv(input logic w, input logic o, input logic [15:0] a,
			input logic [7:0] d, input logic [1:0] p, input logic pol);
		logic act, strb;
		cyc = 0;
		stb = 0;
		cs = 0;
		both = 0;
		@(posedge pclk);
		move_valid <= 1'b1;
		move_req <= '{w, o, a, d};
		do begin
			@(posedge pclk);
		end while (move_ready !== 1'b1);
		move_valid <= 1'b0;
		do begin
			@(posedge pclk);
			cyc++;
			@(negedge pclk);
			act = cs_pin_oe[p] === 1'b1 && cs_pin_out[p] === pol;
			strb = ext_rd_n === 1'b0 || ext_wr_n === 1'b0;
			stb += int'(strb);
			cs += int'(act);
			both += int'(act && strb);
		end while (move_done !== 1'b1 && cyc < 100);
	endtask
	task automatic print_verdict();
		$display("comparisons %0d mismatches %0d", n_tests, num_errors);
		if (num_errors == 0 && n_tests > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask
	// ==========
	// watchdog: the whole run needs under a thousand clocks
	initial begin
		repeat (20000) @(posedge pclk);
		num_errors++;
		print_verdict();
	end
	// ==========
	// main sequence
	initial begin
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h0;
		move_valid = 1'b0;
		move_req = '0;
		pin1_drv = 8'hff;
		lat = 4'h0;
		num_errors = 0;
		n_tests = 0;
		repeat (20) @(posedge pclk);
		presetn <= 1'b1;
		for (int i = 0; i < 5; i++) begin
			rreg(rs_idx[i], rs_val[i], 1'b0);
		end
		rreg(8'h91, 8'h00, 1'b1);
		$display("reset values done");
		for (int i = 0; i < 13; i++) begin
			r = rows[i];
			cfg(r);
			mv(r.wr, r.onchip, r.addr, r.addr[7:0] ^ 8'hc3, r.pin, r.pol);
			n = r.onchip ? 2 : int'(r.st) + 2;
			chk(cyc, n * CPM);
			chk(stb, r.onchip ? 0 : (n - 1) * CPM);
			chk(cs, r.hit ? (n - 1) * CPM : 0);
			chk(both, cs);
			if (!r.wr && !r.onchip) begin
				chk(move_rdata, r.addr[7:0] ^ 8'h5a);
			end
			$display("row %0d done", i);
		end
		pin1_drv <= 8'h3c;
		wreg(IDX_PORT1, 8'ha5);
		repeat (4) @(posedge pclk);
		rreg(IDX_PORT1, 8'h24, 1'b0);
		rreg(IDX_PORT1_LATCH, 8'ha5, 1'b0);
		// pins 0..2 are plain I/O, pin 3 still an idle active-low select
		wreg(IDX_PORT4, 8'h04);
		repeat (4) @(posedge pclk);
		rreg(IDX_PORT4, 8'h0c, 1'b0);
		rreg(IDX_PORT4_LATCH, 8'h04, 1'b0);
		$display("port reads done");
		// slow part: the short strobe misses the data, a stretched one catches it
		lat <= 4'h8;
		wreg(IDX_CLK_STRETCH, 8'h00);
		mv(1'b0, 1'b0, 16'h1236, 8'h00, 2'h0, 1'b1);
		chk({31'h0, move_rdata === 8'h6c}, 32'h0);
		wreg(IDX_CLK_STRETCH, 8'h03);
		mv(1'b0, 1'b0, 16'h1237, 8'h00, 2'h0, 1'b1);
		chk(move_rdata, 8'h6d);
		lat <= 4'h0;
		mv(1'b1, 1'b0, 16'h1240, 8'hc3, 2'h0, 1'b1);
		mv(1'b0, 1'b0, 16'h1240, 8'h00, 2'h0, 1'b1);
		chk(move_rdata, 8'hc3);
		$display("slow and back-to-back done");
		wreg(IDX_CLK_STRETCH, 8'h07);
		@(posedge pclk);
		move_valid <= 1'b1;
		move_req <= '{1'b0, 1'b0, 16'h1234, 8'h00};
		@(posedge pclk);
		move_valid <= 1'b0;
		repeat (6) @(posedge pclk);
		presetn <= 1'b0;
		@(negedge pclk);
		chk({29'h0, ext_rd_n, move_ready, move_done}, 32'h6);
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		rreg(IDX_CLK_STRETCH, 8'h01, 1'b0);
		mv(1'b0, 1'b0, 16'h1234, 8'h00, 2'h0, 1'b1);
		chk(cyc, 3 * CPM);
		$display("mid-run reset done");
		print_verdict();
	end
endmodule
